// ===== ufdb_map.vh
`ifndef UFDB_MAP_VH
`define UFDB_MAP_VH

// ==========================================================
// Register offsets (byte addresses)
`define UFDB_OFS_IRQ_STATUS   16'h4800
`define UFDB_OFS_IRQ_ENABLE   16'h4804
`define UFDB_OFS_CORE_RESET   16'h4808
`define UFDB_OFS_IN_CTRL      16'h4900
`define UFDB_OFS_IN_CNT_LO    16'h4904
`define UFDB_OFS_IN_CNT_MID   16'h4908
`define UFDB_OFS_IN_CNT_HI    16'h490C
`define UFDB_OFS_OUT_CTRL     16'h4910
`define UFDB_OFS_OUT_CNT_LO   16'h4914
`define UFDB_OFS_OUT_CNT_MID  16'h4918
`define UFDB_OFS_OUT_CNT_HI   16'h491C
`define UFDB_OFS_IN_DATA      16'h4A00
`define UFDB_OFS_OUT_DATA     16'h4B00

// ==========================================================
// Field positions
`define UFDB_BIT_IN_DONE      0
`define UFDB_BIT_OUT_DONE     1
`define UFDB_BIT_GRP_LO       4
`define UFDB_BIT_GRP_HI       5
`define UFDB_BIT_SOFT_RESET   0
`define UFDB_BIT_DMA_ENABLE   0
`define UFDB_BIT_REQ_IDLE     1
`define UFDB_BIT_END_CAUSE    2

// ==========================================================
// Reset values
`define UFDB_RST_BYTE         8'h00
`define UFDB_RST_WORD         32'h00000000
`define UFDB_RST_COUNT        24'h000000

// ==========================================================
// Sizes
`define UFDB_FIFO_DEPTH       4
`define UFDB_FIFO_AW          2

`endif

// ===== ufdb_fifo.v
`timescale 1ns/10ps
module ufdb_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	localparam [AW:0] FULL_COUNT = DEPTH;

	reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_reg;
	reg  [AW-1:0]    rd_ptr_reg;
	reg  [AW:0]      fill_reg;
	wire             push;
	wire             pop;

	assign in_ready_o  = (fill_reg != FULL_COUNT);
	assign out_valid_o = (fill_reg != {(AW+1){1'b0}});
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			fill_reg   <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push & ~pop) begin
				fill_reg <= fill_reg + {{AW{1'b0}}, 1'b1};
			end else if (pop & ~push) begin
				fill_reg <= fill_reg - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

// ===== ufdb_byte_cnt.v
`timescale 1ns/10ps
`include "ufdb_map.vh"
module ufdb_byte_cnt (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ld_lo_i,
	input  wire        ld_mid_i,
	input  wire        ld_hi_i,
	input  wire [7:0]  ld_data_i,
	input  wire        dec_i,
	output reg  [23:0] count_o,
	output wire        last_o
);
	// The next decrement brings the count to zero
	assign last_o = (count_o == 24'h000001);

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= `UFDB_RST_COUNT;
		end else if (dec_i) begin
			if (count_o != 24'h000000) begin
				count_o <= count_o - 24'h000001;
			end
		end else begin
			if (ld_lo_i) begin
				count_o[7:0] <= ld_data_i;
			end
			if (ld_mid_i) begin
				count_o[15:8] <= ld_data_i;
			end
			if (ld_hi_i) begin
				count_o[23:16] <= ld_data_i;
			end
		end
	end
endmodule

// ===== ufdb_bridge.v
`timescale 1ns/10ps
`include "ufdb_map.vh"
module ufdb_bridge (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [15:0] addr_i,
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [31:0] wdata_i,
	output reg  [31:0] rdata_o,
	output reg         irq_o,
	output reg         core_soft_reset_o,
	input  wire        core_group_lo_pending_i,
	input  wire        core_group_hi_pending_i,
	input  wire        in_core_dma_request_i,
	input  wire        out_core_dma_request_i,
	input  wire        out_core_transfer_stop_i,
	output reg         in_dmac_request_o,
	output reg         out_dmac_request_o,
	output wire [7:0]  in_core_data_o,
	output wire        in_core_valid_o,
	input  wire        in_core_ready_i,
	input  wire [7:0]  out_core_data_i,
	input  wire        out_core_valid_i,
	output wire        out_core_ready_o
);
	// ==========================================================
	// Address decode
	function sel;
		input [15:0] a;
		input [15:0] ofs;
		begin
			sel = (a == ofs);
		end
	endfunction

	wire w_irq_status = wr_i & sel(addr_i, `UFDB_OFS_IRQ_STATUS);
	wire w_irq_enable = wr_i & sel(addr_i, `UFDB_OFS_IRQ_ENABLE);
	wire w_core_reset = wr_i & sel(addr_i, `UFDB_OFS_CORE_RESET);
	wire w_in_ctrl    = wr_i & sel(addr_i, `UFDB_OFS_IN_CTRL);
	wire w_out_ctrl   = wr_i & sel(addr_i, `UFDB_OFS_OUT_CTRL);
	wire w_in_data    = wr_i & sel(addr_i, `UFDB_OFS_IN_DATA);
	wire r_out_data   = rd_i & sel(addr_i, `UFDB_OFS_OUT_DATA);

	// ==========================================================
	// State
	reg        in_done_flag_reg;
	reg        out_done_flag_reg;
	reg  [5:0] irq_enable_reg;
	reg        in_dma_enable_reg;
	reg        out_dma_enable_reg;
	reg        in_dma_end_cause_reg;
	reg        out_dma_end_cause_reg;
	reg        in_end_pend_reg;
	reg        out_end_pend_reg;
	reg        in_req_q_reg;

	// ==========================================================
	// Buffers
	wire       in_fifo_ready;
	wire       out_fifo_valid;
	wire [7:0] out_fifo_data;

	// In bytes are taken only while in DMA is enabled, out bytes are popped regardless; a write into a full buffer is dropped
	wire in_push = w_in_data & in_dma_enable_reg & in_fifo_ready;
	wire out_pop = r_out_data & out_fifo_valid;

	ufdb_fifo #(
		.WIDTH (8),
		.DEPTH (`UFDB_FIFO_DEPTH),
		.AW    (`UFDB_FIFO_AW)
	) u_in_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (in_push),
		.in_ready_o  (in_fifo_ready),
		.in_data_i   (wdata_i[7:0]),
		.out_valid_o (in_core_valid_o),
		.out_ready_i (in_core_ready_i),
		.out_data_o  (in_core_data_o)
	);

	ufdb_fifo #(
		.WIDTH (8),
		.DEPTH (`UFDB_FIFO_DEPTH),
		.AW    (`UFDB_FIFO_AW)
	) u_out_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (out_core_valid_i),
		.in_ready_o  (out_core_ready_o),
		.in_data_i   (out_core_data_i),
		.out_valid_o (out_fifo_valid),
		.out_ready_i (r_out_data),
		.out_data_o  (out_fifo_data)
	);

	// ==========================================================
	// Byte counters
	wire [23:0] in_byte_counter;
	wire [23:0] out_byte_counter;
	wire        in_last;
	wire        out_last;

	// Counter loads are ignored while the endpoint is enabled
	ufdb_byte_cnt u_in_cnt (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ld_lo_i   (wr_i & ~in_dma_enable_reg & sel(addr_i, `UFDB_OFS_IN_CNT_LO)),
		.ld_mid_i  (wr_i & ~in_dma_enable_reg & sel(addr_i, `UFDB_OFS_IN_CNT_MID)),
		.ld_hi_i   (wr_i & ~in_dma_enable_reg & sel(addr_i, `UFDB_OFS_IN_CNT_HI)),
		.ld_data_i (wdata_i[7:0]),
		.dec_i     (in_push),
		.count_o   (in_byte_counter),
		.last_o    (in_last)
	);

	ufdb_byte_cnt u_out_cnt (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ld_lo_i   (wr_i & ~out_dma_enable_reg & sel(addr_i, `UFDB_OFS_OUT_CNT_LO)),
		.ld_mid_i  (wr_i & ~out_dma_enable_reg & sel(addr_i, `UFDB_OFS_OUT_CNT_MID)),
		.ld_hi_i   (wr_i & ~out_dma_enable_reg & sel(addr_i, `UFDB_OFS_OUT_CNT_HI)),
		.ld_data_i (wdata_i[7:0]),
		.dec_i     (out_pop & out_dma_enable_reg),
		.count_o   (out_byte_counter),
		.last_o    (out_last)
	);

	// ==========================================================
	// End detection
	wire in_zero_end  = in_dma_enable_reg & in_push & in_last;
	wire out_zero_end = out_dma_enable_reg & out_pop & out_last;
	wire in_req_fall  = in_dma_enable_reg & in_req_q_reg & ~in_core_dma_request_i;
	wire out_core_end = out_dma_enable_reg & out_core_transfer_stop_i;
	wire in_drained   = in_end_pend_reg & ~in_core_valid_o;
	wire out_drained  = out_end_pend_reg & ~out_fifo_valid;
	wire in_done_set  = in_zero_end | in_drained;
	wire out_done_set = out_zero_end | out_drained;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_req_q_reg <= 1'b0;
		end else begin
			in_req_q_reg <= in_core_dma_request_i;
		end
	end

	// ==========================================================
	// In endpoint control
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_dma_enable_reg    <= 1'b0;
			in_dma_end_cause_reg <= 1'b0;
			in_end_pend_reg      <= 1'b0;
		end else begin
			if (in_zero_end) begin
				in_dma_enable_reg    <= 1'b0;
				in_dma_end_cause_reg <= 1'b0;
			end else if (in_req_fall) begin
				in_dma_enable_reg <= 1'b0;
				in_end_pend_reg   <= 1'b1;
			end else if (w_in_ctrl) begin
				in_dma_enable_reg <= wdata_i[`UFDB_BIT_DMA_ENABLE];
				if (wdata_i[`UFDB_BIT_DMA_ENABLE]) begin
					in_dma_end_cause_reg <= 1'b0;
				end
			end
			if (in_drained) begin
				in_end_pend_reg      <= 1'b0;
				in_dma_end_cause_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Out endpoint control
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_dma_enable_reg    <= 1'b0;
			out_dma_end_cause_reg <= 1'b0;
			out_end_pend_reg      <= 1'b0;
		end else begin
			if (out_zero_end) begin
				out_dma_enable_reg    <= 1'b0;
				out_dma_end_cause_reg <= 1'b0;
			end else if (out_core_end) begin
				out_dma_enable_reg <= 1'b0;
				out_end_pend_reg   <= 1'b1;
			end else if (w_out_ctrl) begin
				out_dma_enable_reg <= wdata_i[`UFDB_BIT_DMA_ENABLE];
				if (wdata_i[`UFDB_BIT_DMA_ENABLE]) begin
					out_dma_end_cause_reg <= 1'b0;
				end
			end
			if (out_drained) begin
				out_end_pend_reg      <= 1'b0;
				out_dma_end_cause_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Done flags, set wins over a clearing write
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_done_flag_reg  <= 1'b0;
			out_done_flag_reg <= 1'b0;
		end else begin
			if (in_done_set) begin
				in_done_flag_reg <= 1'b1;
			end else if (w_irq_status & wdata_i[`UFDB_BIT_IN_DONE]) begin
				in_done_flag_reg <= 1'b0;
			end
			if (out_done_set) begin
				out_done_flag_reg <= 1'b1;
			end else if (w_irq_status & wdata_i[`UFDB_BIT_OUT_DONE]) begin
				out_done_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Enables, core reset, interrupt and DMA requests
	wire [5:0] status_vec = {core_group_hi_pending_i, core_group_lo_pending_i, 2'b00,
		out_done_flag_reg, in_done_flag_reg};

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_enable_reg     <= 6'h00;
			core_soft_reset_o  <= 1'b0;
			irq_o              <= 1'b0;
			in_dmac_request_o  <= 1'b0;
			out_dmac_request_o <= 1'b0;
		end else begin
			if (w_irq_enable) begin
				irq_enable_reg <= wdata_i[5:0] & 6'h33;
			end
			if (w_core_reset) begin
				core_soft_reset_o <= wdata_i[`UFDB_BIT_SOFT_RESET];
			end
			irq_o <= |(status_vec & irq_enable_reg);
			// Requests stall while the in buffer is full; out requests follow buffered data
			in_dmac_request_o <= in_dma_enable_reg & in_core_dma_request_i & in_fifo_ready
				& ~in_zero_end & ~in_req_fall;
			out_dmac_request_o <= out_dma_enable_reg & out_fifo_valid & ~out_zero_end;
		end
	end

	// ==========================================================
	// Read data
	reg [7:0] rd_byte;

	always @* begin
		rd_byte = 8'h00;
		case (addr_i)
			`UFDB_OFS_IRQ_STATUS:  rd_byte = {2'b00, status_vec};
			`UFDB_OFS_IRQ_ENABLE:  rd_byte = {2'b00, irq_enable_reg};
			`UFDB_OFS_CORE_RESET:  rd_byte = {7'h00, core_soft_reset_o};
			`UFDB_OFS_IN_CTRL:     rd_byte = {5'h00, in_dma_end_cause_reg, ~in_core_dma_request_i,
				in_dma_enable_reg};
			`UFDB_OFS_OUT_CTRL:    rd_byte = {5'h00, out_dma_end_cause_reg, ~out_core_dma_request_i,
				out_dma_enable_reg};
			`UFDB_OFS_IN_CNT_LO:   rd_byte = in_byte_counter[7:0];
			`UFDB_OFS_IN_CNT_MID:  rd_byte = in_byte_counter[15:8];
			`UFDB_OFS_IN_CNT_HI:   rd_byte = in_byte_counter[23:16];
			`UFDB_OFS_OUT_CNT_LO:  rd_byte = out_byte_counter[7:0];
			`UFDB_OFS_OUT_CNT_MID: rd_byte = out_byte_counter[15:8];
			`UFDB_OFS_OUT_CNT_HI:  rd_byte = out_byte_counter[23:16];
			`UFDB_OFS_OUT_DATA:    rd_byte = out_fifo_valid ? out_fifo_data : 8'h00;
			default:               rd_byte = 8'h00;
		endcase
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= `UFDB_RST_WORD;
		end else if (rd_i) begin
			rdata_o <= {24'h000000, rd_byte};
		end
	end
endmodule

// ===== ufdb_core_model.sv
`timescale 1ns/10ps
module ufdb_core_model (
	input  logic       clk_i,
	input  logic       stall_i,
	input  logic [7:0] in_data_i,
	input  logic       in_valid_i,
	output logic       in_ready_o,
	output logic [7:0] out_data_o,
	output logic       out_valid_o,
	input  logic       out_ready_i
);
	logic [7:0] rx_q[$];
	assign in_ready_o = !stall_i;
	initial begin
		out_valid_o = 1'b0;
		out_data_o  = 8'hA5;
	end
	// ==========
	// Collect bytes forwarded by the bridge
	always @(posedge clk_i) begin
		if (in_valid_i && in_ready_o) begin
			rx_q.push_back(in_data_i);
		end
	end
	// Offer a byte until taken; the line then shows garbage
	task send(input logic [7:0] b);
		@(posedge clk_i);
		#2;
		out_data_o  = b;
		out_valid_o = 1'b1;
		while (!out_ready_i) begin
			@(posedge clk_i);
			#2;
		end
		@(posedge clk_i);
		#2;
		out_valid_o = 1'b0;
		out_data_o  = ~b;
	endtask
endmodule

// ===== ufdb_chk.sv
`timescale 1ns/10ps
module ufdb_chk (
	input logic        clk_i,
	input logic        rst_i,
	input logic [15:0] addr_i,
	input logic        wr_i,
	input logic        rd_i,
	input logic [31:0] wdata_i,
	input logic [31:0] rdata_o,
	input logic        irq_o,
	input logic        core_soft_reset_o,
	input logic        core_group_lo_pending_i,
	input logic        core_group_hi_pending_i,
	input logic        in_core_dma_request_i,
	input logic        in_dmac_request_o,
	input logic        in_core_valid_o,
	input logic        in_core_ready_i,
	input logic [7:0]  in_core_data_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// Sequences
	sequence s_en_wr(logic [7:0] v);
		wr_i && addr_i == 16'h4804 && wdata_i[7:0] == v;
	endsequence
	sequence s_hi_rd;
		core_group_hi_pending_i[*2] ##0 (rd_i && addr_i == 16'h4800);
	endsequence
	// ==========
	// Assertions
	chk_rst_write: assert property (wr_i && addr_i == 16'h4808 |=> core_soft_reset_o == $past(wdata_i[0]))
		else $error("soft reset not written");
	chk_rst_hold: assert property (!(wr_i && addr_i == 16'h4808) |=> $stable(core_soft_reset_o))
		else $error("soft reset moved");
	chk_req_mask: assert property (in_dmac_request_o |-> $past(in_core_dma_request_i))
		else $error("request without core request");
	chk_rd_upper: assert property (rd_i |=> rdata_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	chk_hi_read: assert property (s_hi_rd |=> rdata_o[5])
		else $error("group hi bit clear");
	chk_lo_read: assert property ($stable(core_group_lo_pending_i) && rd_i && addr_i == 16'h4800
		|=> rdata_o[4] == $past(core_group_lo_pending_i))
		else $error("group lo bit wrong");
	chk_idle_read: assert property ($stable(in_core_dma_request_i) && rd_i && addr_i == 16'h4900
		|=> rdata_o[1] == !$past(in_core_dma_request_i))
		else $error("request idle bit wrong");
	chk_in_hold: assert property (in_core_valid_o && !in_core_ready_i |=> in_core_valid_o && $stable(in_core_data_o))
		else $error("in byte dropped");
	chk_irq_mask: assert property (s_en_wr(8'h00) ##1 !wr_i |=> !irq_o)
		else $error("irq while masked");
	chk_irq_raise: assert property (s_en_wr(8'h20) ##1 (core_group_hi_pending_i && !wr_i)[*2] |=> irq_o)
		else $error("irq missing");
endmodule
bind ufdb_bridge ufdb_chk u_chk (
	.clk_i                  (clk_i),
	.rst_i                  (rst_i),
	.addr_i                 (addr_i),
	.wr_i                   (wr_i),
	.rd_i                   (rd_i),
	.wdata_i                (wdata_i),
	.rdata_o                (rdata_o),
	.irq_o                  (irq_o),
	.core_soft_reset_o      (core_soft_reset_o),
	.core_group_lo_pending_i(core_group_lo_pending_i),
	.core_group_hi_pending_i(core_group_hi_pending_i),
	.in_core_dma_request_i  (in_core_dma_request_i),
	.in_dmac_request_o      (in_dmac_request_o),
	.in_core_valid_o        (in_core_valid_o),
	.in_core_ready_i        (in_core_ready_i),
	.in_core_data_o         (in_core_data_o)
);

// ===== testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [31:0] wdata_i = 32'h00000000;
	logic [1:0]  grp = 2'b00;
	logic        in_req = 1'b0;
	logic        out_req = 1'b0;
	logic        stop = 1'b0;
	logic        stall = 1'b0;
	logic [31:0] rdata_o;
	logic        irq_o, srst_o, in_dmac, out_dmac;
	logic [7:0]  icd, ocd;
	logic        icv, icr, ocv, ocr;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cycles = 0;
	ufdb_bridge dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .core_soft_reset_o(srst_o),
		.core_group_lo_pending_i(grp[0]), .core_group_hi_pending_i(grp[1]),
		.in_core_dma_request_i(in_req), .out_core_dma_request_i(out_req),
		.out_core_transfer_stop_i(stop), .in_dmac_request_o(in_dmac), .out_dmac_request_o(out_dmac),
		.in_core_data_o(icd), .in_core_valid_o(icv), .in_core_ready_i(icr),
		.out_core_data_i(ocd), .out_core_valid_i(ocv), .out_core_ready_o(ocr));
	ufdb_core_model core (.clk_i(clk_i), .stall_i(stall), .in_data_i(icd), .in_valid_i(icv),
		.in_ready_o(icr), .out_data_o(ocd), .out_valid_o(ocv), .out_ready_i(ocr));
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict;
		end
	end
	// ==========
	// Bus access
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		cyc(1);
		addr_i = a;
		wdata_i = {24'h000000, d};
		wr_i = 1'b1;
		cyc(1);
		wr_i = 1'b0;
	endtask
	task ck(input logic [15:0] a, input logic [7:0] e, input string nm);
		cyc(1);
		addr_i = a;
		rd_i = 1'b1;
		cyc(1);
		rd_i = 1'b0;
		`CHK(nm, e, rdata_o[7:0])
	endtask
	// ==========
	// Scenarios
	task t_regs;
		logic [15:0] a[9] = '{16'h4800, 16'h4804, 16'h4808, 16'h4904, 16'h4908, 16'h490C, 16'h491C, 16'h4B00, 16'h4000};
		foreach (a[i]) ck(a[i], 8'h00, "reset value");
		ck(16'h4900, 8'h02, "in ctrl reset");
		ck(16'h4910, 8'h02, "out ctrl reset");
	endtask
	task t_srst;
		wr_reg(16'h4808, 8'h01);
		`CHK("soft reset on", 1'b1, srst_o)
		ck(16'h4808, 8'h01, "soft reset bit");
		wr_reg(16'h4808, 8'h00);
		`CHK("soft reset off", 1'b0, srst_o)
	endtask
	task t_irq;
		for (int b = 0; b < 2; b++) begin
			grp = 2'b01 << b;
			ck(16'h4800, 8'h10 << b, "group status");
			wr_reg(16'h4804, 8'h20 >> b);
			cyc(2);
			`CHK("irq masked", 1'b0, irq_o)
			wr_reg(16'h4804, 8'h10 << b);
			cyc(2);
			`CHK("irq enabled", 1'b1, irq_o)
			grp = 2'b00;
			ck(16'h4800, 8'h00, "group cleared");
			wr_reg(16'h4804, 8'h00);
		end
	endtask
	task t_in;
		stall = 1'b1;
		wr_reg(16'h4908, 8'hA5);
		ck(16'h4908, 8'hA5, "count mid");
		wr_reg(16'h4908, 8'h00);
		wr_reg(16'h4904, 8'h03);
		wr_reg(16'h4900, 8'h01);
		wr_reg(16'h4904, 8'h07);
		in_req = 1'b1;
		cyc(2);
		`CHK("in request", 1'b1, in_dmac)
		ck(16'h4900, 8'h01, "in ctrl busy");
		for (int i = 0; i < 3; i++) wr_reg(16'h4A00, 8'hC0 + i);
		ck(16'h4900, 8'h00, "end by count");
		ck(16'h4904, 8'h00, "count zero");
		ck(16'h4800, 8'h01, "in done");
		wr_reg(16'h4800, 8'h00);
		ck(16'h4800, 8'h01, "done kept");
		wr_reg(16'h4800, 8'h01);
		ck(16'h4800, 8'h00, "done cleared");
		stall = 1'b0;
		in_req = 1'b0;
		cyc(4);
		`CHK("rx count", 3, core.rx_q.size())
		for (int i = 0; i < 3; i++) `CHK("rx byte", 8'hC0 + i, core.rx_q[i])
	endtask
	task t_drop;
		core.rx_q.delete();
		stall = 1'b1;
		wr_reg(16'h4904, 8'h0A);
		wr_reg(16'h4900, 8'h01);
		in_req = 1'b1;
		for (int i = 0; i < 5; i++) wr_reg(16'h4A00, 8'h50 + i);
		ck(16'h4904, 8'h06, "count at full");
		in_req = 1'b0;
		cyc(2);
		ck(16'h4800, 8'h00, "done waits drain");
		stall = 1'b0;
		cyc(6);
		ck(16'h4800, 8'h01, "done after drain");
		ck(16'h4900, 8'h06, "end by request");
		`CHK("rx count", 4, core.rx_q.size())
		wr_reg(16'h4900, 8'h01);
		ck(16'h4900, 8'h03, "cause cleared");
		wr_reg(16'h4900, 8'h00);
		wr_reg(16'h4800, 8'h01);
	endtask
	task t_out;
		out_req = 1'b1;
		wr_reg(16'h4914, 8'h02);
		wr_reg(16'h4910, 8'h01);
		ck(16'h4910, 8'h01, "out ctrl busy");
		core.send(8'h3C);
		core.send(8'hC3);
		out_req = 1'b0;
		cyc(2);
		`CHK("out request", 1'b1, out_dmac)
		ck(16'h4B00, 8'h3C, "out byte 0");
		ck(16'h4B00, 8'hC3, "out byte 1");
		ck(16'h4800, 8'h02, "out done");
		ck(16'h4910, 8'h02, "out end by count");
		wr_reg(16'h4800, 8'h02);
		wr_reg(16'h4914, 8'h05);
		wr_reg(16'h4910, 8'h01);
		core.send(8'h77);
		stop = 1'b1;
		cyc(2);
		ck(16'h4800, 8'h00, "stop waits drain");
		stop = 1'b0;
		ck(16'h4B00, 8'h77, "short byte");
		cyc(2);
		ck(16'h4800, 8'h02, "done after stop");
		ck(16'h4910, 8'h06, "out end by stop");
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		cyc(10);
		rst_i = 1'b0;
		t_regs;
		t_srst;
		t_irq;
		t_in;
		t_drop;
		t_out;
		give_verdict;
	end
endmodule
